//--- rtl/tai_rx_antenna_txramp_config.sv
// Receive path, antenna dwell and transmit ramp-up configuration with its datapath.
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module tai_rx_antenna_txramp_config
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        nrst,
	// Avalon-MM register slave.
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// Receive serial side.
	input  wire logic        rx_serial_bit,
	input  wire logic        rx_bit_valid,
	input  wire logic        rx_sof_detect,
	output logic             rx_medium_bit,
	output logic             rx_medium_valid,
	output logic      [7:0]  rx_byte,
	output logic             rx_byte_valid,
	output logic             rx_calc_enable,
	output logic             rx_bias_strip,
	// Transmit serial side.
	input  wire logic [7:0]  tx_byte,
	input  wire logic        tx_byte_load,
	input  wire logic        tx_bit_tick,
	input  wire logic        tx_sof_sent,
	output logic             tx_serial_bit,
	output logic             tx_calc_enable,
	// Antenna diversity.
	input  wire logic [7:0]  rssi,
	input  wire logic        ant_search,
	output logic             antenna_select,
	output logic             dwell_sample,
	// Transmit ramp-up strobes, active low.
	input  wire logic        tx_ramp_start,
	input  wire logic        tx_ramp_end,
	output logic             tx_strobe_first_n,
	output logic             tx_strobe_second_n,
	output logic             tx_strobe_third_n
);
	import tai_cfg_pkg::*;

	logic [7:0]  recv_cfg_reg;
	logic [7:0]  dwell_reg;
	logic [7:0]  ramp_gaps_reg;
	logic        clock_range_reg;
	logic        sw_ant_reg;
	logic        waitrequest_reg;
	logic [31:0] readdata_reg;
	logic        wr_take;
	logic [7:0]  status_val;

	// Maps a byte address to a register index, or to all ones when unaligned.
	function automatic logic [5:0] reg_index(input logic [7:0] addr);
		reg_index = (addr[1:0] == 2'b00) ? addr[7:2] : 6'h3f;
	endfunction

	assign waitrequest = waitrequest_reg;
	assign readdata    = readdata_reg;
	assign wr_take     = write && !waitrequest_reg;

	// Each request is answered one cycle after it is raised.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			waitrequest_reg <= 1'b1;
		end
		else
		begin
			waitrequest_reg <= !((read || write) && waitrequest_reg);
		end
	end

	a_wait_one_cycle: assert property (@(posedge clk) disable iff (!nrst)
		(read || write) && waitrequest |=> !waitrequest)
		else $error("Register request was not answered after one cycle.");

	// Read data are captured at the edge that ends the wait.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			readdata_reg <= 32'h0000_0000;
		end
		else if (read && waitrequest_reg)
		begin
			unique case (reg_index(address))
				RECV_CFG_IDX:  readdata_reg <= {24'h00_0000, recv_cfg_reg};
				DWELL_IDX:     readdata_reg <= {24'h00_0000, dwell_reg};
				RAMP_GAPS_IDX: readdata_reg <= {24'h00_0000, ramp_gaps_reg};
				CONTROL_IDX:   readdata_reg <= {30'h0000_0000, sw_ant_reg, clock_range_reg};
				STATUS_IDX:    readdata_reg <= {24'h00_0000, status_val};
				default:       readdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	// Configuration registers take write data at the edge after the wait ends, while waitrequest is low.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			recv_cfg_reg    <= RECV_CFG_RST;
			dwell_reg       <= DWELL_RST;
			ramp_gaps_reg   <= RAMP_GAPS_RST;
			clock_range_reg <= CONTROL_RST[CLK_RANGE_BIT];
			sw_ant_reg      <= CONTROL_RST[SW_ANT_BIT];
		end
		else if (wr_take)
		begin
			if (reg_index(address) == RECV_CFG_IDX)
				recv_cfg_reg <= writedata[7:0];
			if (reg_index(address) == DWELL_IDX)
				dwell_reg <= {writedata[DIV_EN_BIT], 1'b0, writedata[DWELL_MSB:DWELL_LSB]};
			if (reg_index(address) == RAMP_GAPS_IDX)
				ramp_gaps_reg <= writedata[7:0];
			if (reg_index(address) == CONTROL_IDX)
			begin
				clock_range_reg <= writedata[CLK_RANGE_BIT];
				if (writedata[SW_LOAD_BIT])
					sw_ant_reg <= writedata[SW_ANT_BIT];
			end
		end
	end

	a_write_recv_cfg: assert property (@(posedge clk) disable iff (!nrst)
		write && !waitrequest && address == {RECV_CFG_IDX, 2'b00}
		|=> recv_cfg_reg == $past(writedata[7:0]))
		else $error("Receive configuration write was not stored.");

	// Receive input selection, inversion and loopback.
	logic       loop_en;
	logic       bit_msb_first;
	logic [3:0] hdr_len;
	logic       tx_bit_valid_reg;
	logic       tx_serial_reg;
	logic       rx_medium_reg;
	logic       rx_medium_v_reg;

	assign loop_en       = recv_cfg_reg[LOOPBACK_BIT];
	assign bit_msb_first = recv_cfg_reg[BIT_ORDER_BIT];
	assign hdr_len       = recv_cfg_reg[HDR_LEN_MSB:HDR_LEN_LSB];

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rx_medium_reg   <= 1'b0;
			rx_medium_v_reg <= 1'b0;
		end
		else if (loop_en)
		begin
			rx_medium_reg   <= tx_serial_reg;
			rx_medium_v_reg <= tx_bit_valid_reg;
		end
		else
		begin
			rx_medium_reg   <= rx_serial_bit ^ recv_cfg_reg[RX_INVERT_BIT];
			rx_medium_v_reg <= rx_bit_valid;
		end
	end

	// Frame start detection downstream sees this stream before any byte reordering.
	assign rx_medium_bit   = rx_medium_reg;
	assign rx_medium_valid = rx_medium_v_reg;

	a_rx_invert_path: assert property (@(posedge clk) disable iff (!nrst)
		rx_bit_valid && !loop_en
		|=> rx_medium_bit == ($past(rx_serial_bit) ^ $past(recv_cfg_reg[RX_INVERT_BIT])))
		else $error("Receive bit was not passed with the selected polarity.");

	a_loop_route: assert property (@(posedge clk) disable iff (!nrst)
		loop_en |=> rx_medium_valid == $past(tx_bit_valid_reg))
		else $error("Loopback did not route the transmit stream.");

	// Receive serial-to-parallel conversion.
	logic [7:0] rx_shift_reg;
	logic [2:0] rx_bit_cnt_reg;
	logic [7:0] rx_byte_reg;
	logic       rx_byte_v_reg;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rx_shift_reg   <= 8'h00;
			rx_bit_cnt_reg <= 3'd0;
			rx_byte_reg    <= 8'h00;
			rx_byte_v_reg  <= 1'b0;
		end
		else
		begin
			rx_byte_v_reg <= 1'b0;
			if (rx_sof_detect)
			begin
				rx_bit_cnt_reg <= 3'd0;
			end
			else if (rx_medium_v_reg)
			begin
				if (bit_msb_first)
					rx_shift_reg <= {rx_shift_reg[6:0], rx_medium_reg};
				else
					rx_shift_reg <= {rx_medium_reg, rx_shift_reg[7:1]};
				rx_bit_cnt_reg <= rx_bit_cnt_reg + 3'd1;
				if (rx_bit_cnt_reg == LAST_BIT)
				begin
					rx_byte_v_reg <= 1'b1;
					rx_byte_reg   <= bit_msb_first ? {rx_shift_reg[6:0], rx_medium_reg}
						: {rx_medium_reg, rx_shift_reg[7:1]};
				end
			end
		end
	end

	assign rx_byte       = rx_byte_reg;
	assign rx_byte_valid = rx_byte_v_reg;

	a_msb_first_shift: assert property (@(posedge clk) disable iff (!nrst)
		rx_medium_valid && bit_msb_first && !rx_sof_detect
		|=> rx_shift_reg[0] == $past(rx_medium_bit))
		else $error("Most significant bit first shift took the wrong position.");

	// Transmit parallel-to-serial conversion.
	logic [7:0] tx_shift_reg;
	logic [2:0] tx_bit_cnt_reg;
	logic       tx_full_reg;
	logic       tx_byte_done;

	assign tx_byte_done = tx_bit_tick && tx_full_reg && (tx_bit_cnt_reg == LAST_BIT);

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tx_shift_reg     <= 8'h00;
			tx_bit_cnt_reg   <= 3'd0;
			tx_full_reg      <= 1'b0;
			tx_serial_reg    <= 1'b0;
			tx_bit_valid_reg <= 1'b0;
		end
		else
		begin
			tx_bit_valid_reg <= tx_bit_tick && tx_full_reg;
			if (tx_byte_load)
			begin
				tx_shift_reg   <= tx_byte;
				tx_bit_cnt_reg <= 3'd0;
				tx_full_reg    <= 1'b1;
			end
			else if (tx_bit_tick && tx_full_reg)
			begin
				tx_serial_reg  <= bit_msb_first ? tx_shift_reg[7] : tx_shift_reg[0];
				tx_shift_reg   <= bit_msb_first ? {tx_shift_reg[6:0], 1'b0}
					: {1'b0, tx_shift_reg[7:1]};
				tx_bit_cnt_reg <= tx_bit_cnt_reg + 3'd1;
				if (tx_bit_cnt_reg == LAST_BIT)
					tx_full_reg <= 1'b0;
			end
		end
	end

	assign tx_serial_bit = tx_serial_reg;

	// Header byte counting for the receive (0) and transmit (1) paths.
	logic [1:0] hdr_start;
	logic [1:0] hdr_byte;
	logic [1:0] calc_reg;
	logic [3:0] hdr_cnt_reg [2];

	assign hdr_start = {tx_sof_sent, rx_sof_detect};
	assign hdr_byte  = {tx_byte_done, rx_byte_v_reg};

	generate
		for (genvar p = 0; p < 2; p++)
		begin : g_hdr
			always_ff @(posedge clk or negedge nrst)
			begin
				if (!nrst)
				begin
					hdr_cnt_reg[p] <= 4'h0;
					calc_reg[p]    <= 1'b0;
				end
				else if (hdr_start[p])
				begin
					hdr_cnt_reg[p] <= 4'h0;
					calc_reg[p]    <= (hdr_len == 4'h0);
				end
				else if (hdr_byte[p] && !calc_reg[p])
				begin
					hdr_cnt_reg[p] <= hdr_cnt_reg[p] + 4'h1;
					calc_reg[p]    <= (hdr_cnt_reg[p] + 4'h1 == hdr_len);
				end
			end
		end
	endgenerate

	assign rx_calc_enable = calc_reg[0];
	assign tx_calc_enable = calc_reg[1];

	// Bias decoding runs only on bytes past the header and only when enabled.
	logic bias_strip_reg;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			bias_strip_reg <= 1'b0;
		else
			bias_strip_reg <= recv_cfg_reg[BIAS_RM_BIT] && calc_reg[0];
	end

	assign rx_bias_strip = bias_strip_reg;

	sequence s_rx_frame_start;
		rx_sof_detect && hdr_len == 4'h0;
	endsequence

	a_hdr_zero_len: assert property (@(posedge clk) disable iff (!nrst)
		s_rx_frame_start |=> rx_calc_enable)
		else $error("Zero header length did not enable calculation at once.");

	a_sof_restart: assert property (@(posedge clk) disable iff (!nrst)
		rx_sof_detect && hdr_len != 4'h0 |=> !rx_calc_enable && hdr_cnt_reg[0] == 4'h0)
		else $error("Header count did not restart at frame start.");

	a_bias_gate: assert property (@(posedge clk) disable iff (!nrst)
		!recv_cfg_reg[BIAS_RM_BIT] |=> !rx_bias_strip)
		else $error("Bias removal active while disabled.");

	// Antenna dwell measurement and selection.
	logic       dwell_on;
	logic       dwell_done;
	logic       search_d_reg;
	logic       meas_ant_reg;
	logic       best_ant_reg;
	logic [7:0] rssi_a_reg;
	logic [7:0] rssi_b_reg;
	logic       dwell_sample_reg;
	logic       antenna_reg;

	assign dwell_on = ant_search && (dwell_reg[DWELL_MSB:DWELL_LSB] != 6'h00);

	step_timer u_dwell_timer
	(
		.clk         (clk),
		.nrst        (nrst),
		.start       ((ant_search && !search_d_reg) || dwell_done),
		.enable      (dwell_on),
		.clock_range (clock_range_reg),
		.steps       (dwell_reg[DWELL_MSB:DWELL_LSB]),
		.done        (dwell_done)
	);

	// Dwell periods run whatever the diversity enable says.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			search_d_reg     <= 1'b0;
			meas_ant_reg     <= 1'b0;
			best_ant_reg     <= 1'b0;
			rssi_a_reg       <= 8'h00;
			rssi_b_reg       <= 8'h00;
			dwell_sample_reg <= 1'b0;
		end
		else
		begin
			search_d_reg     <= ant_search;
			dwell_sample_reg <= dwell_done;
			if (dwell_done)
			begin
				meas_ant_reg <= !meas_ant_reg;
				if (meas_ant_reg)
					rssi_b_reg <= rssi;
				else
					rssi_a_reg <= rssi;
			end
			if (search_d_reg && !ant_search)
				best_ant_reg <= (rssi_b_reg > rssi_a_reg);
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			antenna_reg <= 1'b0;
		else if (!dwell_reg[DIV_EN_BIT])
			antenna_reg <= sw_ant_reg;
		else
			antenna_reg <= dwell_on ? meas_ant_reg : best_ant_reg;
	end

	assign antenna_select = antenna_reg;
	assign dwell_sample   = dwell_sample_reg;

	a_sw_antenna: assert property (@(posedge clk) disable iff (!nrst)
		!dwell_reg[DIV_EN_BIT] |=> antenna_select == $past(sw_ant_reg))
		else $error("Software antenna choice not driven with diversity off.");

	a_dwell_off: assert property (@(posedge clk) disable iff (!nrst)
		dwell_reg[DWELL_MSB:DWELL_LSB] == 6'h00 |=> !dwell_sample)
		else $error("Dwell switching ran with a zero dwell field.");

	// Transmit ramp-up strobe sequencing.
	ramp_state_t ramp_state_reg;
	logic        ramp_done;
	logic        strobe1_n_reg;
	logic        strobe2_n_reg;
	logic        strobe3_n_reg;
	logic [3:0]  gap1;
	logic [3:0]  gap2;
	logic [3:0]  ramp_steps;

	assign gap1 = ramp_gaps_reg[GAP1_MSB:GAP1_LSB];
	assign gap2 = ramp_gaps_reg[GAP2_MSB:GAP2_LSB];

	// The first gap is timed only from idle with a nonzero first gap and while in it.
	assign ramp_steps = ((ramp_state_reg == RAMP_IDLE && gap1 != 4'h0)
		|| ramp_state_reg == RAMP_GAP1) ? gap1 : gap2;

	step_timer u_ramp_timer
	(
		.clk         (clk),
		.nrst        (nrst),
		.start       ((ramp_state_reg == RAMP_IDLE && tx_ramp_start)
			|| (ramp_state_reg == RAMP_GAP1 && ramp_done)),
		.enable      (!tx_ramp_end),
		.clock_range (clock_range_reg),
		.steps       ({2'b00, ramp_steps}),
		.done        (ramp_done)
	);

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ramp_state_reg <= RAMP_IDLE;
			strobe1_n_reg  <= 1'b1;
			strobe2_n_reg  <= 1'b1;
			strobe3_n_reg  <= 1'b1;
		end
		else if (tx_ramp_end)
		begin
			ramp_state_reg <= RAMP_IDLE;
			strobe1_n_reg  <= 1'b1;
			strobe2_n_reg  <= 1'b1;
			strobe3_n_reg  <= 1'b1;
		end
		else
		begin
			unique case (ramp_state_reg)
				RAMP_IDLE:
					if (tx_ramp_start)
					begin
						strobe1_n_reg <= 1'b0;
						if (gap1 == 4'h0 && gap2 == 4'h0)
						begin
							strobe2_n_reg  <= 1'b0;
							strobe3_n_reg  <= 1'b0;
							ramp_state_reg <= RAMP_ON;
						end
						else if (gap1 == 4'h0)
						begin
							strobe2_n_reg  <= 1'b0;
							ramp_state_reg <= RAMP_GAP2;
						end
						else
						begin
							ramp_state_reg <= RAMP_GAP1;
						end
					end
				RAMP_GAP1:
					if (ramp_done)
					begin
						strobe2_n_reg  <= 1'b0;
						if (gap2 == 4'h0)
						begin
							strobe3_n_reg  <= 1'b0;
							ramp_state_reg <= RAMP_ON;
						end
						else
						begin
							ramp_state_reg <= RAMP_GAP2;
						end
					end
				RAMP_GAP2:
					if (ramp_done)
					begin
						strobe3_n_reg  <= 1'b0;
						ramp_state_reg <= RAMP_ON;
					end
				RAMP_ON:
					ramp_state_reg <= RAMP_ON;
			endcase
		end
	end

	assign tx_strobe_first_n  = strobe1_n_reg;
	assign tx_strobe_second_n = strobe2_n_reg;
	assign tx_strobe_third_n  = strobe3_n_reg;

	assign status_val = {1'b0, meas_ant_reg, calc_reg[1], calc_reg[0],
		!strobe3_n_reg, !strobe2_n_reg, !strobe1_n_reg, antenna_reg};

	sequence s_ramp_gap1_go;
		ramp_state_reg == RAMP_IDLE && tx_ramp_start && !tx_ramp_end && gap1 == 4'h1
			&& !clock_range_reg;
	endsequence

	sequence s_second_held;
		(!tx_strobe_first_n && tx_strobe_second_n && !tx_ramp_end && !clock_range_reg
			&& gap1 == 4'h1) [*8];
	endsequence

	sequence s_second_tail;
		(!tx_strobe_first_n && tx_strobe_second_n && !tx_ramp_end && !clock_range_reg
			&& gap1 == 4'h1) [*4];
	endsequence

	a_gap1_timing: assert property (@(posedge clk) disable iff (!nrst)
		s_ramp_gap1_go ##1 s_second_held ##1 s_second_held ##1 s_second_tail
		|=> !tx_strobe_second_n)
		else $error("Second strobe not asserted one step after the first.");

	a_gap2_hold: assert property (@(posedge clk) disable iff (!nrst)
		ramp_state_reg == RAMP_GAP2 && !ramp_done && !tx_ramp_end |=> tx_strobe_third_n)
		else $error("Third strobe asserted before its gap ended.");

	a_strobe_order: assert property (@(posedge clk) disable iff (!nrst)
		!tx_strobe_second_n |-> !tx_strobe_first_n)
		else $error("Second strobe asserted without the first.");

endmodule

//--- inc/tai_cfg_pkg.sv
// Register map, field layout and timing constants of the transceiver configuration block.
package tai_cfg_pkg;

	// Register indices; the bus byte address is four times the index.
	localparam logic [5:0] RECV_CFG_IDX  = 6'h03;
	localparam logic [5:0] DWELL_IDX     = 6'h04;
	localparam logic [5:0] RAMP_GAPS_IDX = 6'h05;
	localparam logic [5:0] CONTROL_IDX   = 6'h08;
	localparam logic [5:0] STATUS_IDX    = 6'h09;

	// Receive configuration fields.
	localparam int LOOPBACK_BIT  = 7;
	localparam int BIT_ORDER_BIT = 6;
	localparam int BIAS_RM_BIT   = 5;
	localparam int RX_INVERT_BIT = 4;
	localparam int HDR_LEN_MSB   = 3;
	localparam int HDR_LEN_LSB   = 0;

	// Antenna dwell timer fields.
	localparam int DIV_EN_BIT    = 7;
	localparam int DWELL_RSV_BIT = 6;
	localparam int DWELL_MSB     = 5;
	localparam int DWELL_LSB     = 0;

	// Ramp-up gap fields.
	localparam int GAP1_MSB = 7;
	localparam int GAP1_LSB = 4;
	localparam int GAP2_MSB = 3;
	localparam int GAP2_LSB = 0;

	// Control register fields.
	localparam int CLK_RANGE_BIT = 0;
	localparam int SW_ANT_BIT    = 1;
	localparam int SW_LOAD_BIT   = 2;

	// Status register fields.
	localparam int ST_ANT_BIT     = 0;
	localparam int ST_STROBE1_BIT = 1;
	localparam int ST_STROBE2_BIT = 2;
	localparam int ST_STROBE3_BIT = 3;
	localparam int ST_RX_CALC_BIT = 4;
	localparam int ST_TX_CALC_BIT = 5;
	localparam int ST_MEAS_BIT    = 6;

	// Reset values.
	localparam logic [7:0] RECV_CFG_RST  = 8'h00;
	localparam logic [7:0] DWELL_RST     = 8'h00;
	localparam logic [7:0] RAMP_GAPS_RST = 8'h00;
	localparam logic [7:0] CONTROL_RST   = 8'h00;

	// Timing step in input clock periods for each clock range.
	localparam logic [5:0] STEP_CLKS_LOW  = 6'h14;
	localparam logic [5:0] STEP_CLKS_HIGH = 6'h28;

	// Index of the last bit in one serial byte.
	localparam logic [2:0] LAST_BIT = 3'h7;

	typedef enum logic [1:0] {RAMP_IDLE, RAMP_GAP1, RAMP_GAP2, RAMP_ON} ramp_state_t;

endpackage

//--- rtl/step_timer.sv
// Counts a number of 20- or 40-clock timing steps after a start pulse.
`timescale 1ns/1ps
module step_timer
(
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       nrst,
	// Control.
	input  wire logic       start,
	input  wire logic       enable,
	input  wire logic       clock_range,
	input  wire logic [5:0] steps,
	// Result.
	output logic            done
);
	import tai_cfg_pkg::*;

	logic [5:0] unit_cnt_reg;
	logic [5:0] step_cnt_reg;
	logic       active_reg;
	logic [5:0] unit_last;

	assign unit_last = (clock_range ? STEP_CLKS_HIGH : STEP_CLKS_LOW) - 6'h01;
	assign done = active_reg && enable && (unit_cnt_reg == unit_last)
		&& (step_cnt_reg == steps - 6'h01);

	// Step counting restarts from zero on every start pulse taken while enabled.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			unit_cnt_reg <= 6'h00;
			step_cnt_reg <= 6'h00;
			active_reg   <= 1'b0;
		end
		else if (!enable)
		begin
			active_reg <= 1'b0;
		end
		else if (start)
		begin
			unit_cnt_reg <= 6'h00;
			step_cnt_reg <= 6'h00;
			active_reg   <= (steps != 6'h00);
		end
		else if (active_reg)
		begin
			if (unit_cnt_reg == unit_last)
			begin
				unit_cnt_reg <= 6'h00;
				step_cnt_reg <= step_cnt_reg + 6'h01;
				if (step_cnt_reg == steps - 6'h01)
				begin
					active_reg <= 1'b0;
				end
			end
			else
			begin
				unit_cnt_reg <= unit_cnt_reg + 6'h01;
			end
		end
	end

endmodule

//--- tb/phy_model.sv
// Behavioural radio front end that feeds serial receive bits and signal strength.
`timescale 1ns/1ps
module phy_model
(
	// Clock and antenna.
	input  wire logic       clk,
	input  wire logic       antenna_select,
	// Serial receive side.
	output logic            rx_serial_bit,
	output logic            rx_bit_valid,
	output logic            rx_sof_detect,
	output logic      [7:0] rssi
);
	// Antenna 1 always reports the stronger signal.
	assign rssi = antenna_select ? 8'h40 : 8'h20;
	initial
	begin
		rx_serial_bit = 1'b0;
		rx_bit_valid = 1'b0;
		rx_sof_detect = 1'b0;
	end
	task automatic sof();
		@(posedge clk);
		rx_sof_detect <= 1'b1;
		@(posedge clk);
		rx_sof_detect <= 1'b0;
	endtask
	// Sends bit 0 first; the line shows the inverse once a bit is over.
	task automatic send_byte(input logic [7:0] b);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk);
			rx_serial_bit <= b[i];
			rx_bit_valid <= 1'b1;
			@(posedge clk);
			rx_serial_bit <= ~b[i];
			rx_bit_valid <= 1'b0;
		end
	endtask
endmodule

//--- tb/tai_rx_antenna_txramp_config_bench.sv
// Self-checking bench for the receive, antenna and ramp-up configuration block.
`timescale 1ns/1ps
module tai_rx_antenna_txramp_config_bench;
	import tai_cfg_pkg::*;
	logic        clk, nrst, read, write, waitrequest;
	logic [7:0]  address, rx_byte, got_byte, tx_byte, rssi;
	logic [31:0] writedata, readdata, q;
	logic        rx_serial_bit, rx_bit_valid, rx_sof_detect, rx_byte_valid;
	logic        rx_calc_enable, rx_bias_strip, tx_byte_load, tx_bit_tick, tx_sof_sent;
	logic        ant_search, antenna_select, dwell_sample, tx_ramp_start, tx_ramp_end;
	logic        s1_n, s2_n, s3_n;
	logic        tx_serial_bit, tx_calc_enable, rx_medium_bit;
	int          err_count = 0;
	int          total_checks = 0;
	int          cyc = 0;
	localparam logic [7:0] RC = {RECV_CFG_IDX, 2'b00};
	localparam logic [7:0] DW = {DWELL_IDX, 2'b00};
	localparam logic [7:0] RG = {RAMP_GAPS_IDX, 2'b00};
	localparam logic [7:0] CT = {CONTROL_IDX, 2'b00};
	localparam logic [7:0] SR = {STATUS_IDX, 2'b00};

	tai_rx_antenna_txramp_config tai_rx_antenna_txramp_config_i (.clk(clk), .nrst(nrst),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .rx_serial_bit(rx_serial_bit),
		.rx_bit_valid(rx_bit_valid), .rx_sof_detect(rx_sof_detect),
		.rx_medium_bit(rx_medium_bit),
		.rx_medium_valid(), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid),
		.rx_calc_enable(rx_calc_enable), .rx_bias_strip(rx_bias_strip), .tx_byte(tx_byte),
		.tx_byte_load(tx_byte_load), .tx_bit_tick(tx_bit_tick), .tx_sof_sent(tx_sof_sent),
		.tx_serial_bit(tx_serial_bit), .tx_calc_enable(tx_calc_enable), .rssi(rssi),
		.ant_search(ant_search),
		.antenna_select(antenna_select), .dwell_sample(dwell_sample),
		.tx_ramp_start(tx_ramp_start), .tx_ramp_end(tx_ramp_end),
		.tx_strobe_first_n(s1_n), .tx_strobe_second_n(s2_n), .tx_strobe_third_n(s3_n));
	phy_model phy_model_i (.clk(clk), .antenna_select(antenna_select),
		.rx_serial_bit(rx_serial_bit), .rx_bit_valid(rx_bit_valid),
		.rx_sof_detect(rx_sof_detect), .rssi(rssi));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (rx_byte_valid === 1'b1)
			got_byte <= rx_byte;
		if (cyc == 20000)
		begin
			err_count++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("checks=%0d errors=%0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		address <= a;
		writedata <= {24'h00_0000, d};
		read <= ~wr;
		write <= wr;
		do
			@(posedge clk);
		while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic t_regs();
		bus(0, RC, 0);
		chk(q, 32'h0000_0000);
		bus(0, RG, 0);
		chk(q, 32'h0000_0000);
		bus(0, DW, 0);
		chk(q & 32'h0000_00BF, 32'h0000_0000);
		bus(1, RC, 8'h5A);
		bus(1, RG, 8'hC3);
		bus(1, DW, 8'h85);
		bus(1, 8'h0D, 8'hFF);
		bus(0, RC, 0);
		chk(q, 32'h0000_005A);
		bus(0, RG, 0);
		chk(q, 32'h0000_00C3);
		bus(0, DW, 0);
		chk(q & 32'h0000_00BF, 32'h0000_0085);
		bus(0, 8'h3C, 0);
		chk(q, 32'h0000_0000);
	endtask
	task automatic t_rx(input logic [7:0] cfg, input logic [7:0] b, input logic [7:0] e);
		bus(1, RC, cfg);
		phy_model_i.sof();
		phy_model_i.send_byte(b);
		repeat (3) @(posedge clk);
		chk(got_byte, e);
		chk(rx_medium_bit, (!b[7]) ^ cfg[4]);
	endtask
	task automatic t_loop(input logic [7:0] cfg, input logic last);
		bus(1, RC, cfg);
		phy_model_i.sof();
		@(posedge clk);
		tx_sof_sent <= 1'b1;
		tx_byte_load <= 1'b1;
		tx_byte <= 8'h96;
		@(posedge clk);
		tx_sof_sent <= 1'b0;
		tx_byte_load <= 1'b0;
		repeat (8)
		begin
			@(posedge clk);
			tx_bit_tick <= 1'b1;
			@(posedge clk);
			tx_bit_tick <= 1'b0;
		end
		repeat (4) @(posedge clk);
		chk(got_byte, 8'h96);
		chk(tx_serial_bit, last);
		chk(tx_calc_enable, 1);
	endtask
	task automatic t_hdr();
		bus(1, RC, 8'h22);
		phy_model_i.sof();
		repeat (2) @(posedge clk);
		chk(rx_calc_enable, 0);
		phy_model_i.send_byte(8'h11);
		repeat (3) @(posedge clk);
		chk(rx_calc_enable, 0);
		phy_model_i.send_byte(8'h22);
		repeat (3) @(posedge clk);
		chk(rx_calc_enable, 1);
		@(posedge clk);
		chk(rx_bias_strip, 1);
	endtask
	task automatic t_ramp(input logic cr, input logic [7:0] g);
		int n1, n2, n3, st;
		st = cr ? 40 : 20;
		n1 = 0;
		n2 = 0;
		n3 = 0;
		bus(1, CT, {7'h00, cr});
		bus(1, RG, g);
		@(posedge clk);
		tx_ramp_start <= 1'b1;
		@(posedge clk);
		tx_ramp_start <= 1'b0;
		for (int k = 1; k < 100; k++)
		begin
			@(negedge clk);
			if (s1_n === 1'b0 && n1 == 0) n1 = k;
			if (s2_n === 1'b0 && n2 == 0) n2 = k;
			if (s3_n === 1'b0 && n3 == 0) n3 = k;
		end
		chk(n1, 1);
		chk(n2, 1 + g[7:4] * st);
		chk(n3, 1 + (g[7:4] + g[3:0]) * st);
		bus(0, SR, 0);
		chk(q[3:1], 3'b111);
		bus(0, CT, 0);
		chk(q, {31'h0000_0000, cr});
		@(posedge clk);
		tx_ramp_end <= 1'b1;
		@(posedge clk);
		tx_ramp_end <= 1'b0;
		@(negedge clk);
		chk({s1_n, s2_n, s3_n}, 3'b111);
	endtask
	task automatic pulse(output int t);
		int n;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (dwell_sample !== 1'b1 && n < 300);
		t = cyc;
	endtask
	task automatic t_dwell();
		int t0, t1, n;
		bus(1, CT, 8'h00);
		bus(1, DW, 8'h02);
		ant_search <= 1'b1;
		pulse(t0);
		pulse(t1);
		chk(t1 - t0, 40);
		bus(1, DW, 8'h82);
		pulse(t0);
		pulse(t1);
		@(posedge clk);
		ant_search <= 1'b0;
		repeat (4) @(negedge clk);
		chk(antenna_select, 1);
		bus(1, DW, 8'h80);
		ant_search <= 1'b1;
		n = 0;
		repeat (200)
		begin
			@(negedge clk);
			if (dwell_sample !== 1'b0) n++;
		end
		chk(n, 0);
		ant_search <= 1'b0;
		bus(1, DW, 8'h00);
		bus(1, CT, 8'h06);
		repeat (2) @(negedge clk);
		chk(antenna_select, 1);
	endtask
	initial
	begin
		nrst = 1'b0;
		{read, write, tx_byte_load, tx_bit_tick, tx_sof_sent} = 5'h00;
		{ant_search, tx_ramp_start, tx_ramp_end} = 3'h0;
		address = 8'h00;
		writedata = 32'h0000_0000;
		tx_byte = 8'h00;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_rx(8'h00, 8'h1E, 8'h1E);
		t_rx(8'h40, 8'h1E, 8'h78);
		t_rx(8'h10, 8'h1E, 8'hE1);
		t_rx(8'h50, 8'h1E, 8'h87);
		t_hdr();
		t_loop(8'h81, 1'b1);
		t_loop(8'hC1, 1'b0);
		t_ramp(1'b0, 8'h12);
		t_ramp(1'b1, 8'h11);
		t_ramp(1'b0, 8'h00);
		t_ramp(1'b0, 8'h02);
		t_dwell();
		stop_test();
	end
endmodule
